// *** hw/rof_defs.svh ***
// Offsets, field positions and reset values of the resampler output pacing FIFO.
// Assumes word-indexed Avalon-MM addressing with 32-bit data.
`ifndef ROF_DEFS_SVH
`define ROF_DEFS_SVH

// ----------------------------------------
// Register map (word index)
// ----------------------------------------
`define ROF_ADDR_W 4
`define ROF_CTL_IDX 4'ha
`define ROF_STAT_IDX 4'hb

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define ROF_EN_BIT 14
`define ROF_SIZE_HI 13
`define ROF_SIZE_LO 12
`define ROF_DLY_HI 11
`define ROF_DLY_LO 0
`define ROF_DLY_W 12
`define ROF_CTL_RST 15'h0000

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define ROF_STAT_OVF 0
`define ROF_STAT_TERM 1
`define ROF_STAT_CNT_LO 4

// ----------------------------------------
// Sizes
// ----------------------------------------
`define ROF_FIFO_DEPTH 4
`define ROF_DATA_W 24
`define ROF_WORD_W 32

`endif

// *** hw/rof_fifo.sv ***
// Parameterised synchronous FIFO with valid and ready on both sides.
// Assumes a single clock and an active-low asynchronous reset.
`timescale 1ns/1ps

module rof_fifo #(
  parameter int W = 24,
  parameter int DEPTH = 4,
  parameter int CW = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // FIFO channel
  rof_fifo_if.fifo bus
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
  } rof_fifo_st_t;

  rof_fifo_st_t s_q;
  rof_fifo_st_t s_d;
  logic push;
  logic pop;

  assign bus.push_ready = (s_q.cnt != CW'(DEPTH));
  assign bus.pop_valid = (s_q.cnt != '0);
  assign bus.pop_data = s_q.mem[s_q.rp];
  assign bus.count = s_q.cnt;
  assign push = bus.push_valid && bus.push_ready;
  assign pop = bus.pop_valid && bus.pop_ready;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wp] = bus.push_data;
      s_d.wp = (s_q.wp == AW'(DEPTH - 1)) ? '0 : s_q.wp + 1'b1;
    end
    if (pop) begin
      s_d.rp = (s_q.rp == AW'(DEPTH - 1)) ? '0 : s_q.rp + 1'b1;
    end
    if (push && !pop) begin
      s_d.cnt = s_q.cnt + 1'b1;
    end else if (pop && !push) begin
      s_d.cnt = s_q.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  fifo_capacity_a: assert property (@(posedge clk) disable iff (!rstn) // RL7
    s_q.cnt <= CW'(DEPTH))
    else $error("FIFO count above its depth");
endmodule

// *** hw/rof_fifo_if.sv ***
// Push and pop channel between the pacing top and its FIFO.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps

interface rof_fifo_if #(
  parameter int W = 24,
  parameter int CW = 3
);
  logic push_valid;
  logic push_ready;
  logic [W-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [W-1:0] pop_data;
  logic [CW-1:0] count;

  modport fifo (
    input push_valid, push_data, pop_ready,
    output push_ready, pop_valid, pop_data, count
  );
  modport user (
    output push_valid, push_data, pop_ready,
    input push_ready, pop_valid, pop_data, count
  );
endinterface

// *** hw/rof_pace_ctr.sv ***
// Output spacing counter: reloads on each release, counts down to a hold state.
// Assumes load is asserted by the pacing top in the cycle a sample leaves.
`timescale 1ns/1ps

module rof_pace_ctr #(
  parameter int CTW = 12
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Control
  input wire logic load,
  input wire logic [CTW-1:0] load_val,
  // Status
  output logic at_term
);
  typedef struct packed {
    logic [CTW-1:0] cnt;
  } rof_ctr_st_t;

  rof_ctr_st_t s_q;
  rof_ctr_st_t s_d;

  assign at_term = (s_q.cnt == '0);

  always_comb begin
    s_d = s_q;
    if (load) begin
      s_d.cnt = load_val; // RL8 RL10
    end else if (!at_term) begin
      s_d.cnt = s_q.cnt - 1'b1; // RL10
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  ctr_reload_a: assert property (@(posedge clk) disable iff (!rstn) // RL10
    load |=> s_q.cnt == $past(load_val))
    else $error("Spacing counter missed its reload");

  ctr_countdown_a: assert property (@(posedge clk) disable iff (!rstn) // RL10
    (!load && !at_term) |=> s_q.cnt == $past(s_q.cnt) - 1'b1)
    else $error("Spacing counter did not step down");

  ctr_hold_a: assert property (@(posedge clk) disable iff (!rstn) // RL8
    (!load && at_term) |=> at_term)
    else $error("Spacing counter left its hold state");
endmodule

// *** hw/rof_pkg.sv ***
// Types shared by the resampler output pacing FIFO modules.
// Assumes rof_defs.svh is on the include path.
`include "rof_defs.svh"

package rof_pkg;

  // ----------------------------------------
  // Control register image
  // ----------------------------------------
  typedef struct packed {
    logic en;
    logic [1:0] size;
    logic [`ROF_DLY_W-1:0] delay;
  } rof_ctl_t;

endpackage

// *** hw/rof_top.sv ***
// Resampler output pacing FIFO with offset-word controls and Avalon-MM slave.
// Assumes a single 100 MHz clock; the serial offset shifter and compute engine
// sit on the same clock and hand over data without synchronisers.
//
// Functional notes
// RL1 - Enabled offset word reaches the resampler
// RL2 - Disabled offset forces contribution to zero
// RL3 - Size code selects 8/16/24/32 bit word
// RL4 - Samples leave only on spacing timeout
// RL5 - Empty FIFO at hold state passes through
// RL6 - Early samples wait in FIFO until timeout
// RL7 - Pacing FIFO holds four samples
// RL8 - Spacing equals programmed value plus one
// RL9 - Software programs spacing slightly below target
// RL10 - Counter reloads per release, one per timeout
//
// Design decisions made here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`include "rof_defs.svh"

module rof_top #(
  parameter int DW = `ROF_DATA_W,
  parameter int DEPTH = `ROF_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Avalon-MM slave
  input wire logic [`ROF_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Samples from the compute engine
  input wire logic in_valid,
  input wire logic [DW-1:0] in_data,
  output logic in_ready,
  // Paced samples to the output path
  input wire logic out_ready,
  output logic out_valid,
  output logic [DW-1:0] out_data,
  // Offset word from the serial shifter
  input wire logic offset_word_load,
  input wire logic [`ROF_WORD_W-1:0] offset_word_in,
  // Resampler offset and expected word length
  output logic [`ROF_WORD_W-1:0] resampler_offset,
  output logic [5:0] offset_word_len
);
  localparam int CW = $clog2(DEPTH + 1);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic wait_r;
    logic [31:0] rdata;
    rof_pkg::rof_ctl_t ctl;
    logic ovf;
    logic [`ROF_WORD_W-1:0] word;
    logic [`ROF_WORD_W-1:0] off;
    logic [5:0] len;
    logic in_rdy;
    logic ov;
    logic [DW-1:0] od;
  } rof_top_st_t;

  rof_top_st_t s_q;
  rof_top_st_t s_d;

  rof_fifo_if #(.W(DW), .CW(CW)) fif ();
  logic at_term;
  logic bypass;
  logic push;
  logic pop;
  logic release_s;
  logic acc;
  logic [CW:0] cnt_next;

  // ----------------------------------------
  // Offset word helpers
  // ----------------------------------------
  function automatic logic [`ROF_WORD_W-1:0] size_mask(input logic [1:0] sz);
    logic [`ROF_WORD_W-1:0] m;
    m = 32'hffff_ffff;
    case (sz)
      2'h0: m = 32'h0000_00ff;
      2'h1: m = 32'h0000_ffff;
      2'h2: m = 32'h00ff_ffff;
      default: m = 32'hffff_ffff;
    endcase
    return m;
  endfunction

  // ----------------------------------------
  // Submodules
  // ----------------------------------------
  rof_fifo #(.W(DW), .DEPTH(DEPTH), .CW(CW)) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .bus(fif.fifo)
  );

  rof_pace_ctr #(.CTW(`ROF_DLY_W)) u_ctr (
    .clk(clk),
    .rstn(rstn),
    .load(release_s),
    .load_val(s_q.ctl.delay),
    .at_term(at_term)
  );

  // ----------------------------------------
  // Pacing datapath
  // ----------------------------------------
  // Release only at the hold state and only when downstream can take it
  assign pop = fif.pop_valid && at_term && out_ready; // RL4 RL6
  assign bypass = in_valid && s_q.in_rdy && !fif.pop_valid && at_term && out_ready; // RL5
  assign push = in_valid && s_q.in_rdy && !bypass; // RL6
  assign release_s = pop || bypass; // RL10
  assign cnt_next = {1'b0, fif.count} + {{CW{1'b0}}, push} - {{CW{1'b0}}, pop};

  assign fif.push_valid = push;
  assign fif.push_data = in_data;
  assign fif.pop_ready = pop;

  assign acc = (avs_read || avs_write) && !s_q.wait_r;

  always_comb begin
    logic [31:0] ctlv;
    logic [31:0] stv;
    ctlv = '0;
    stv = '0;
    s_d = s_q;
    ctlv[`ROF_EN_BIT] = s_q.ctl.en;
    ctlv[`ROF_SIZE_HI:`ROF_SIZE_LO] = s_q.ctl.size;
    ctlv[`ROF_DLY_HI:`ROF_DLY_LO] = s_q.ctl.delay;
    stv[`ROF_STAT_OVF] = s_q.ovf;
    stv[`ROF_STAT_TERM] = at_term;
    stv[`ROF_STAT_CNT_LO +: CW] = fif.count;

    // One wait state, then one accept cycle
    s_d.wait_r = !((avs_read || avs_write) && s_q.wait_r);
    if ((avs_read || avs_write) && s_q.wait_r) begin
      if (avs_address == `ROF_CTL_IDX) begin
        s_d.rdata = ctlv;
      end else if (avs_address == `ROF_STAT_IDX) begin
        s_d.rdata = stv;
      end else begin
        s_d.rdata = '0;
      end
    end

    if (acc && avs_write) begin
      if (avs_address == `ROF_CTL_IDX) begin
        if (avs_byteenable[0]) begin
          ctlv[7:0] = avs_writedata[7:0];
        end
        if (avs_byteenable[1]) begin
          ctlv[15:8] = avs_writedata[15:8];
        end
        s_d.ctl.en = ctlv[`ROF_EN_BIT];
        s_d.ctl.size = ctlv[`ROF_SIZE_HI:`ROF_SIZE_LO];
        s_d.ctl.delay = ctlv[`ROF_DLY_HI:`ROF_DLY_LO];
      end else if (avs_address == `ROF_STAT_IDX) begin
        if (avs_byteenable[0] && avs_writedata[`ROF_STAT_OVF]) begin
          s_d.ovf = 1'b0;
        end
      end
    end
    // Overflow set wins over a same-cycle clear
    if (in_valid && !s_q.in_rdy) begin
      s_d.ovf = 1'b1;
    end

    // Offset word and resampler contribution
    if (offset_word_load) begin
      s_d.word = offset_word_in;
    end
    s_d.off = s_q.ctl.en ? (s_q.word & size_mask(s_q.ctl.size)) : '0; // RL1 RL2 RL3
    s_d.len = {1'b0, s_q.ctl.size, 3'h0} + 6'h08; // RL3

    // Ready mirrors the FIFO's room in the next cycle
    s_d.in_rdy = (cnt_next < (CW + 1)'(DEPTH)); // RL7
    s_d.ov = release_s; // RL4
    if (pop) begin
      s_d.od = fif.pop_data;
    end else if (bypass) begin
      s_d.od = in_data; // RL5
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '{wait_r: 1'b1, ctl: `ROF_CTL_RST, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_readdata = s_q.rdata;
  assign avs_waitrequest = s_q.wait_r;
  assign in_ready = s_q.in_rdy;
  assign out_valid = s_q.ov;
  assign out_data = s_q.od;
  assign resampler_offset = s_q.off;
  assign offset_word_len = s_q.len;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [`ROF_DLY_W:0] gap_q;
  logic seen_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gap_q <= '0;
      seen_q <= 1'b0;
    end else if (s_q.ov) begin
      gap_q <= '0;
      seen_q <= 1'b1;
    end else if (gap_q != '1) begin
      gap_q <= gap_q + 1'b1;
    end
  end

  offset_apply_a: assert property (@(posedge clk) disable iff (!rstn) // RL1
    (s_q.ctl.en && $stable(s_q.word)) |=> resampler_offset == ($past(s_q.word) & size_mask($past(s_q.ctl.size))))
    else $error("Enabled offset word not applied");

  offset_zero_a: assert property (@(posedge clk) disable iff (!rstn) // RL2
    !s_q.ctl.en |=> resampler_offset == '0)
    else $error("Disabled offset not forced to zero");

  word_size_a: assert property (@(posedge clk) disable iff (!rstn) // RL3
    (rstn && s_q.ctl.size == 2'h0) |=> (resampler_offset[31:8] == '0 && offset_word_len == 6'h08))
    else $error("Eight-bit word size not honoured");

  release_timeout_a: assert property (@(posedge clk) disable iff (!rstn) // RL4
    out_valid |-> $past(at_term))
    else $error("Sample released before timeout");

  bypass_pass_a: assert property (@(posedge clk) disable iff (!rstn) // RL5
    bypass |=> (out_valid && out_data == $past(in_data) && (!at_term || $past(s_q.ctl.delay) == '0)))
    else $error("Pass-through sample not forwarded");

  hold_store_a: assert property (@(posedge clk) disable iff (!rstn) // RL6
    (push && !at_term) |=> (!out_valid && fif.count != '0))
    else $error("Early sample not held");

  spacing_gap_a: assert property (@(posedge clk) disable iff (!rstn) // RL8
    (out_valid && seen_q && $stable(s_q.ctl.delay)) |-> gap_q >= {1'b0, s_q.ctl.delay})
    else $error("Release spacing shorter than programmed");

  one_release_a: assert property (@(posedge clk) disable iff (!rstn) // RL10
    (out_valid && s_q.ctl.delay != '0) |=> !out_valid)
    else $error("Two releases within one timeout");

  no_overfill_a: assert property (@(posedge clk) disable iff (!rstn) // RL7
    (fif.count == CW'(DEPTH)) |-> !in_ready)
    else $error("Ready high while FIFO full");

  // ----------------------------------------
  // Bus, stream handshake, word size and release checks
  // ----------------------------------------
  bus_answer_a: assert property (@(posedge clk) disable iff (!rstn)
    ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest)
    else $error("Bus request not answered after one wait state");

  bus_release_a: assert property (@(posedge clk) disable iff (!rstn)
    !avs_waitrequest |=> avs_waitrequest)
    else $error("Wait request low for more than one cycle");

  read_zero_a: assert property (@(posedge clk) disable iff (!rstn)
    (avs_read && avs_waitrequest && avs_address != `ROF_CTL_IDX && avs_address != `ROF_STAT_IDX) |=> avs_readdata == '0)
    else $error("Unmapped read returned nonzero data");

  ovf_set_a: assert property (@(posedge clk) disable iff (!rstn) // RL7
    (in_valid && !in_ready) |=> s_q.ovf)
    else $error("Refused sample did not flag overflow");

  ready_room_a: assert property (@(posedge clk) disable iff (!rstn) // RL7
    (rstn && fif.count < CW'(DEPTH - 1)) |=> in_ready)
    else $error("Ready low while FIFO has room");

  size_max_a: assert property (@(posedge clk) disable iff (!rstn) // RL3
    (rstn && s_q.ctl.size == 2'h3) |=> offset_word_len == 6'h20)
    else $error("Thirty-two bit word size not honoured");

  size_mid_a: assert property (@(posedge clk) disable iff (!rstn) // RL3
    (rstn && s_q.ctl.size == 2'h1) |=> (resampler_offset[31:16] == '0 && offset_word_len == 6'h10))
    else $error("Sixteen-bit word size not honoured");

  pop_release_a: assert property (@(posedge clk) disable iff (!rstn) // RL6
    pop |=> (out_valid && out_data == $past(fif.pop_data)))
    else $error("Stored sample not released on timeout");

  reload_hold_a: assert property (@(posedge clk) disable iff (!rstn) // RL10
    (release_s && s_q.ctl.delay != '0) |=> !at_term)
    else $error("Spacing counter not reloaded on release");

  one_pop_a: assert property (@(posedge clk) disable iff (!rstn) // RL10
    pop |=> fif.count == $past(fif.count) - 1'b1 + CW'($past(push)))
    else $error("Timeout released other than one sample");
endmodule

// *** sim/rof_engine_model.sv ***
// Compute-engine stand-in that sends bursts of samples, with optional gaps.
// Assumes the pacing top on the same clock; ign pushes without waiting for ready.
`timescale 1ns/1ps

module rof_engine_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Burst control
  input wire logic start,
  input wire logic [3:0] n,
  input wire logic [3:0] gap,
  input wire logic ign,
  // Sample stream
  output logic in_valid,
  output logic [23:0] in_data,
  input wire logic in_ready
);
  logic [3:0] left_q;
  logic [3:0] wait_q;
  logic [23:0] seq_q;

  assign in_valid = (left_q != 4'h0) && (wait_q == 4'h0);
  // Idle data is the inverse, never a stale copy
  assign in_data = in_valid ? seq_q : ~seq_q;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      left_q <= 4'h0;
      wait_q <= 4'h0;
      seq_q <= 24'h0;
    end else if (start) begin
      left_q <= n;
      wait_q <= 4'h0;
    end else if (in_valid && (in_ready || ign)) begin
      left_q <= left_q - 4'h1;
      wait_q <= gap;
      seq_q <= seq_q + 24'h1;
    end else if (wait_q != 4'h0) begin
      wait_q <= wait_q - 4'h1;
    end
  end
endmodule

// *** sim/testbench.sv ***
// Self-checking bench for the resampler output pacing FIFO.
// Assumes rof_defs.svh on the include path and the engine model beside it.
`timescale 1ns/1ps
`include "rof_defs.svh"

module testbench;
  logic clk, rstn, avs_read, avs_write, avs_waitrequest;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, offset_word_in, resampler_offset, q;
  logic in_valid, in_ready, out_ready, out_valid, offset_word_load, start, ign;
  logic [23:0] in_data, out_data;
  logic [5:0] offset_word_len;
  logic [3:0] n, gap;
  logic [23:0] dv[$];
  int tv[$];
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;
  int s0;
  int sent = 0;
  // Enable, size, expected offset, expected length
  localparam logic [40:0] ROWS [5] = '{
    {1'b1, 2'h0, 32'h000000ef, 6'h08}, {1'b1, 2'h1, 32'h0000beef, 6'h10},
    {1'b1, 2'h2, 32'h00adbeef, 6'h18}, {1'b1, 2'h3, 32'hdeadbeef, 6'h20},
    {1'b0, 2'h3, 32'h00000000, 6'h20}};
  // Delay, gap, expected spacing
  localparam logic [15:0] RUNS [4] = '{16'h0001, 16'h1002, 16'h3004, 16'h3607};

  rof_top rof_top_i (
    .clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .in_valid, .in_data, .in_ready,
    .out_ready, .out_valid, .out_data, .offset_word_load, .offset_word_in,
    .resampler_offset, .offset_word_len);
  rof_engine_model rof_engine_model_i (
    .clk, .rstn, .start, .n, .gap, .ign, .in_valid, .in_data, .in_ready);

  // ----------------------------------------
  // Clock, watchdog, output monitor
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #200000;
    n_mismatch++;
    final_report();
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (out_valid === 1'b1) begin
      tv.push_back(cyc);
      dv.push_back(out_data);
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
    int t;
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (avs_waitrequest !== 1'b0 && t < 100);
    if (avs_waitrequest !== 1'b0) n_mismatch++;
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic burst(input logic [3:0] cnt, input logic [3:0] g);
    @(posedge clk);
    s0 = cyc;
    tv.delete();
    dv.delete();
    n <= cnt;
    gap <= g;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
  endtask
  task automatic await_out(input int cnt, input int base);
    int t;
    t = 0;
    while (tv.size() < cnt && t < 300) begin
      @(posedge clk);
      t++;
    end
    check("out_count", tv.size(), cnt);
    for (int k = 0; k < cnt && k < tv.size(); k++) check("out_data", dv[k], base + k);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rstn = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    out_ready = 1'b1;
    offset_word_load = 1'b0;
    offset_word_in = 32'h0;
    start = 1'b0;
    n = 4'h0;
    gap = 4'h0;
    ign = 1'b0;
    repeat (8) @(posedge clk);
    check("in_ready_rst", in_ready, 0);
    check("offset_rst", resampler_offset, 0);
    check("wait_rst", avs_waitrequest, 1);
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1;
    check("len_rst", offset_word_len, 6'h08);
    av(0, `ROF_CTL_IDX, 0);
    check("ctl_rst", q, {17'h0, `ROF_CTL_RST});
    for (int i = 0; i < 5; i++) begin
      av(1, `ROF_CTL_IDX, {17'h0, ROWS[i][40:38], 12'h000});
      av(0, `ROF_CTL_IDX, 0);
      check("ctl_rb", q, {17'h0, ROWS[i][40:38], 12'h000});
      @(posedge clk);
      offset_word_load <= 1'b1;
      offset_word_in <= 32'hdeadbeef;
      @(posedge clk);
      offset_word_load <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      check("offset", resampler_offset, ROWS[i][37:6]);
      check("word_len", offset_word_len, ROWS[i][5:0]);
    end
    av(1, `ROF_CTL_IDX, 32'hffffffff);
    av(0, `ROF_CTL_IDX, 0);
    check("ctl_top", q, 32'h00007fff);
    av(1, 4'h3, 32'hffffffff);
    av(0, 4'h3, 0);
    check("unmapped", q, 0);
    for (int i = 0; i < 4; i++) begin
      // Delays keep five-sample bursts within the FIFO
      av(1, `ROF_CTL_IDX, {28'h0, RUNS[i][15:12]});
      repeat (10) @(posedge clk);
      burst(5, RUNS[i][11:8]);
      await_out(5, sent);
      sent += 5;
      check("latency", tv[0] - s0, 3);
      for (int k = 1; k < tv.size(); k++) check("spacing", tv[k] - tv[k-1], RUNS[i][7:0]);
    end
    av(1, `ROF_CTL_IDX, 0);
    out_ready <= 1'b0;
    ign <= 1'b1;
    burst(6, 4'h0);
    repeat (12) @(posedge clk);
    #1;
    check("full_ready", in_ready, 0);
    check("held", tv.size(), 0);
    av(0, `ROF_STAT_IDX, 0);
    check("stat_ovf", q & 32'h73, 32'h43);
    av(1, `ROF_STAT_IDX, 32'h1);
    av(0, `ROF_STAT_IDX, 0);
    check("stat_clr", q & 32'h73, 32'h42);
    out_ready <= 1'b1;
    ign <= 1'b0;
    await_out(4, sent);
    sent += 6;
    av(0, `ROF_STAT_IDX, 0);
    check("stat_empty", q & 32'h73, 32'h02);
    // Reset in mid-run clears control and handshakes
    av(1, `ROF_CTL_IDX, 32'h00007003);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check("in_ready_mid", in_ready, 0);
    check("len_mid", offset_word_len, 0);
    check("wait_mid", avs_waitrequest, 1);
    @(posedge clk);
    rstn <= 1'b1;
    av(0, `ROF_CTL_IDX, 0);
    check("ctl_mid", q, {17'h0, `ROF_CTL_RST});
    check("offset_mid", resampler_offset, 0);
    final_report();
  end
endmodule
